//--- host_model.sv
// Purpose: host side of the register port
// Assumes: requests change at falling edges, one-cycle write strobe
module host_model (
	input wire logic clk,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr = 0,
	output logic [7:0] reg_addr = 0,
	output logic [7:0] reg_wdata = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	// reserved bits always go out as zero
	function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
		case (a)
			8'h04: legal = d & 8'hEF;
			8'h15: legal = d & 8'h20;
			8'h16: legal = 8'h00;
			8'h17: legal = d & 8'h0A;
			default: legal = d;
		endcase
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1;
		reg_addr = a;
		reg_wdata = legal(a, d);
		@(negedge clk);
		reg_wr = 0;
		// released data line must not look valid
		reg_wdata = ~reg_wdata;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		// combinational answer taken at the rising edge, then step off it
		@(posedge clk);
		d = reg_rdata;
		@(negedge clk);
	endtask
endmodule

//--- leadoff_gpio_config_regs.v
// Purpose: electrode-off, general pin and conversion-mode registers
// Assumes: host register port with one-cycle write strobe; single clock
// Notes: comparator outputs arrive asynchronously and are synchronised
`include "leadoff_gpio_defines.vh"
module leadoff_gpio_config_regs #(
	parameter NCH = 8,
	parameter NPIN = 4
) (
	input wire clk,
	input wire nrst,
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	input wire [NCH*3-1:0] channel_mux_select,
	input wire conversion_done,
	input wire rate_quarter_tick,
	input wire [NCH-1:0] positive_comparator_raw,
	input wire [NCH-1:0] negative_comparator_raw,
	input wire [NPIN-1:0] gpio_pin_in,
	output reg [NPIN-1:0] gpio_pin_out,
	output reg [NPIN-1:0] gpio_pin_oe_n,
	output reg shared_reference_switch,
	output reg single_shot_mode,
	output reg detect_comparator_enable,
	output reg [2:0] comparator_threshold_code,
	output reg [1:0] excitation_current_level,
	output reg [NCH-1:0] positive_detect_active,
	output reg [NCH-1:0] negative_detect_active,
	output reg [NCH-1:0] positive_pull_up,
	output reg [NCH-1:0] negative_pull_up,
	output reg excitation_phase,
	output reg [NCH-1:0] body_drive_to_positive,
	output reg [NCH-1:0] body_drive_to_negative,
	output reg [NCH-1:0] stream_positive_status,
	output reg [NCH-1:0] stream_negative_status
);

// ----------------------------------------
// register storage
// ----------------------------------------
reg [7:0] detection_control_q;
reg [7:0] positive_detect_select_q;
reg [7:0] negative_detect_select_q;
reg [7:0] excitation_direction_swap_q;
reg [7:0] general_io_control_q;
reg [7:0] reference_switch_control_q;
reg [7:0] spare_zero_register_q;
reg [7:0] conversion_comparator_config_q;
reg [NCH-1:0] positive_electrode_off_status_q;
reg [NCH-1:0] negative_electrode_off_status_q;
reg [NPIN-1:0] pin_value_field_q;
reg [NCH-1:0] pos_s1_q, pos_s2_q, pos_s3_q;
reg [NCH-1:0] neg_s1_q, neg_s2_q, neg_s3_q;
reg [NPIN-1:0] pin_s1_q, pin_s2_q, pin_s3_q;
reg [NCH-1:0] pos_clean_q;
reg [NCH-1:0] neg_clean_q;
reg [NPIN-1:0] pin_clean_q;
reg [17:0] excite_cnt_q;
reg excite_phase_q;
wire [NPIN-1:0] dir_is_input;
wire [1:0] fsel;
wire [17:0] half_period;
wire div_tick;
integer i;

assign dir_is_input = general_io_control_q[`GPIO_DIR_MSB:`GPIO_DIR_LSB];
assign fsel = detection_control_q[`FSEL_MSB:`FSEL_LSB];
// phase toggles each half period, so a full period spans twice the count
assign half_period = (fsel == `FSEL_DIV18) ? `DIV18_HALF : `DIV16_HALF;
assign div_tick = (excite_cnt_q == half_period);

// ----------------------------------------
// host writes
// ----------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		detection_control_q <= `RST_ZERO;
		positive_detect_select_q <= `RST_ZERO;
		negative_detect_select_q <= `RST_ZERO;
		excitation_direction_swap_q <= `RST_ZERO;
		general_io_control_q <= `RST_GENERAL_IO;
		reference_switch_control_q <= `RST_ZERO;
		spare_zero_register_q <= `RST_ZERO;
		conversion_comparator_config_q <= `RST_ZERO;
		pin_value_field_q <= {NPIN{1'b0}};
	end else if (reg_wr) begin
		case (reg_addr)
		`OFF_DETECT_CONTROL: detection_control_q <= reg_wdata;
		`OFF_POS_DETECT_SELECT: positive_detect_select_q <= reg_wdata;
		`OFF_NEG_DETECT_SELECT: negative_detect_select_q <= reg_wdata;
		`OFF_DIRECTION_SWAP: excitation_direction_swap_q <= reg_wdata;
		`OFF_GENERAL_IO: begin
			general_io_control_q <= reg_wdata;
			// a write that turns a pin to output also carries its level
			for (i = 0; i < NPIN; i = i + 1) begin
				if (!reg_wdata[`GPIO_DIR_LSB + i] || !dir_is_input[i]) begin
					pin_value_field_q[i] <= reg_wdata[`GPIO_VALUE_LSB + i];
				end
			end
		end
		// reserved bits kept as written; host keeps them zero
		`OFF_REF_SWITCH: reference_switch_control_q <= reg_wdata;
		`OFF_SPARE_ZERO: spare_zero_register_q <= reg_wdata;
		`OFF_CONV_COMP_CFG: conversion_comparator_config_q <= reg_wdata;
		default: begin
		end
		endcase
	end
end

// ----------------------------------------
// input synchronisers, change accepted when stages 2 and 3 agree
// ----------------------------------------
// stage 1 may go metastable, so only stage 2 reads it
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		pos_s1_q <= {NCH{1'b0}};
		pos_s2_q <= {NCH{1'b0}};
		pos_s3_q <= {NCH{1'b0}};
		pos_clean_q <= {NCH{1'b0}};
	end else begin
		pos_s1_q <= positive_comparator_raw;
		pos_s2_q <= pos_s1_q;
		pos_s3_q <= pos_s2_q;
		// a level seen on one edge only is treated as noise
		pos_clean_q <= ((pos_s2_q ~^ pos_s3_q) & pos_s2_q) | ((pos_s2_q ^ pos_s3_q) & pos_clean_q);
	end
end

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		neg_s1_q <= {NCH{1'b0}};
		neg_s2_q <= {NCH{1'b0}};
		neg_s3_q <= {NCH{1'b0}};
		neg_clean_q <= {NCH{1'b0}};
	end else begin
		neg_s1_q <= negative_comparator_raw;
		neg_s2_q <= neg_s1_q;
		neg_s3_q <= neg_s2_q;
		neg_clean_q <= ((neg_s2_q ~^ neg_s3_q) & neg_s2_q) | ((neg_s2_q ^ neg_s3_q) & neg_clean_q);
	end
end

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		pin_s1_q <= {NPIN{1'b0}};
		pin_s2_q <= {NPIN{1'b0}};
		pin_s3_q <= {NPIN{1'b0}};
		pin_clean_q <= {NPIN{1'b0}};
	end else begin
		pin_s1_q <= gpio_pin_in;
		pin_s2_q <= pin_s1_q;
		pin_s3_q <= pin_s2_q;
		pin_clean_q <= ((pin_s2_q ~^ pin_s3_q) & pin_s2_q) | ((pin_s2_q ^ pin_s3_q) & pin_clean_q);
	end
end

// ----------------------------------------
// status capture, once per conversion
// ----------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		positive_electrode_off_status_q <= {NCH{1'b0}};
		negative_electrode_off_status_q <= {NCH{1'b0}};
	end else if (conversion_done) begin
		// disabled comparators report connected
		// select gating leaves unselected channels reading connected
		positive_electrode_off_status_q <= detect_comparator_enable ?
			(pos_clean_q & positive_detect_select_q[NCH-1:0]) : {NCH{1'b0}};
		negative_electrode_off_status_q <= detect_comparator_enable ?
			(neg_clean_q & negative_detect_select_q[NCH-1:0]) : {NCH{1'b0}};
	end
end

// ----------------------------------------
// ac excitation timing
// ----------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		excite_cnt_q <= 18'h00000;
		excite_phase_q <= 1'b0;
	end else begin
		case (fsel)
		`FSEL_DC: begin
			// counter parked at zero so a mode change starts a full half period
			excite_cnt_q <= 18'h00000;
			excite_phase_q <= 1'b0;
		end
		`FSEL_RATE4: begin
			excite_cnt_q <= 18'h00000;
			if (rate_quarter_tick) begin
				excite_phase_q <= ~excite_phase_q;
			end
		end
		default: begin
			excite_cnt_q <= div_tick ? 18'h00000 : excite_cnt_q + 18'h00001;
			if (div_tick) begin
				excite_phase_q <= ~excite_phase_q;
			end
		end
		endcase
	end
end

// ----------------------------------------
// registered outputs
// ----------------------------------------
always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		gpio_pin_out <= {NPIN{1'b0}};
		gpio_pin_oe_n <= {NPIN{1'b1}};
		shared_reference_switch <= 1'b0;
		single_shot_mode <= 1'b0;
		detect_comparator_enable <= 1'b0;
		comparator_threshold_code <= 3'h0;
		excitation_current_level <= 2'h0;
		positive_detect_active <= {NCH{1'b0}};
		negative_detect_active <= {NCH{1'b0}};
		excitation_phase <= 1'b0;
		stream_positive_status <= {NCH{1'b0}};
		stream_negative_status <= {NCH{1'b0}};
	end else begin
		gpio_pin_out <= pin_value_field_q;
		gpio_pin_oe_n <= dir_is_input;
		shared_reference_switch <= reference_switch_control_q[`REF_SWITCH_BIT];
		single_shot_mode <= conversion_comparator_config_q[`SINGLE_SHOT_BIT];
		detect_comparator_enable <= conversion_comparator_config_q[`COMP_ENABLE_BIT];
		// analog DAC decodes 000 as 95%/5% to 111 as 70%/30%
		comparator_threshold_code <= detection_control_q[`THRESH_MSB:`THRESH_LSB];
		excitation_current_level <= detection_control_q[`ILEVEL_MSB:`ILEVEL_LSB];
		positive_detect_active <= positive_detect_select_q[NCH-1:0];
		negative_detect_active <= negative_detect_select_q[NCH-1:0];
		excitation_phase <= excite_phase_q;
		stream_positive_status <= positive_electrode_off_status_q;
		stream_negative_status <= negative_electrode_off_status_q;
	end
end

// ----------------------------------------
// per-channel pull direction and body-drive routing
// ----------------------------------------
genvar ch;
generate
	for (ch = 0; ch < NCH; ch = ch + 1) begin : g_channel
		always @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				positive_pull_up[ch] <= 1'b0;
				negative_pull_up[ch] <= 1'b0;
				body_drive_to_positive[ch] <= 1'b0;
				body_drive_to_negative[ch] <= 1'b0;
			end else begin
				// dc: positive up unless swapped; ac: phase alternates direction
				positive_pull_up[ch] <=
					excitation_direction_swap_q[ch] ^ excite_phase_q ^ 1'b1;
				negative_pull_up[ch] <=
					excitation_direction_swap_q[ch] ^ excite_phase_q;
				body_drive_to_positive[ch] <=
					(channel_mux_select[ch*3 +: 3] == `MUX_BODY_DRIVE_POS);
				body_drive_to_negative[ch] <=
					(channel_mux_select[ch*3 +: 3] == `MUX_BODY_DRIVE_NEG);
			end
		end
	end
endgenerate

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
	case (reg_addr)
	`OFF_DETECT_CONTROL: reg_rdata = detection_control_q;
	`OFF_POS_DETECT_SELECT: reg_rdata = positive_detect_select_q;
	`OFF_NEG_DETECT_SELECT: reg_rdata = negative_detect_select_q;
	`OFF_DIRECTION_SWAP: reg_rdata = excitation_direction_swap_q;
	`OFF_POS_OFF_STATUS: reg_rdata = positive_electrode_off_status_q;
	`OFF_NEG_OFF_STATUS: reg_rdata = negative_electrode_off_status_q;
	// pin levels lag a pin change by four clocks through the synchroniser
	`OFF_GENERAL_IO: reg_rdata = {pin_clean_q, dir_is_input};
	`OFF_REF_SWITCH: reg_rdata = reference_switch_control_q;
	`OFF_SPARE_ZERO: reg_rdata = spare_zero_register_q;
	`OFF_CONV_COMP_CFG: reg_rdata = conversion_comparator_config_q;
	default: reg_rdata = 8'h00;
	endcase
end

endmodule

//--- leadoff_gpio_config_regs_sva.sv
// Purpose: concurrent checks on the register port and derived controls
// Assumes: derived outputs follow a write by two clocks
// Notes: attached by bind after the module
module leadoff_gpio_config_regs_sva #(
	parameter NCH = 8,
	parameter NPIN = 4
) (
	input wire clk,
	input wire nrst,
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata,
	input wire conversion_done,
	input wire [NPIN-1:0] gpio_pin_out,
	input wire [NPIN-1:0] gpio_pin_oe_n,
	input wire shared_reference_switch,
	input wire single_shot_mode,
	input wire detect_comparator_enable,
	input wire [NCH-1:0] stream_negative_status
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_ref_switch: assert property (reg_wr && reg_addr == 8'h15 |->
		##2 shared_reference_switch == $past(reg_wdata[5], 2)) else $error("switch wrong");
	a_single_shot: assert property (reg_wr && reg_addr == 8'h17 |->
		##2 single_shot_mode == $past(reg_wdata[3], 2)) else $error("mode wrong");
	a_comp_enable: assert property (reg_wr && reg_addr == 8'h17 |->
		##2 detect_comparator_enable == $past(reg_wdata[1], 2)) else $error("enable wrong");
	a_cfg_readback: assert property (reg_wr && reg_addr == 8'h17 ##1 reg_addr == 8'h17
		|-> reg_rdata == $past(reg_wdata)) else $error("readback wrong");
	a_status_hold: assert property (reg_addr == 8'h13 && !conversion_done
		##1 reg_addr == 8'h13 |-> $stable(reg_rdata)) else $error("status moved");
	a_pin_dir: assert property (reg_wr && reg_addr == 8'h14 |->
		##2 gpio_pin_oe_n == $past(reg_wdata[3:0], 2)) else $error("direction wrong");
	a_pin_drive: assert property (reg_wr && reg_addr == 8'h14 && !reg_wdata[0] |->
		##2 gpio_pin_out[0] == $past(reg_wdata[4], 2)) else $error("drive wrong");
	a_stream_copy: assert property (reg_addr == 8'h13 |=>
		stream_negative_status == $past(reg_rdata)) else $error("stream wrong");
	a_unmapped_zero: assert property (reg_addr >= 8'h18 |->
		reg_rdata == 8'h00) else $error("unmapped not zero");
	c_capture: cover property (conversion_done && detect_comparator_enable);
	c_pin_write: cover property (reg_wr && reg_addr == 8'h14 && !reg_wdata[0]);
	c_status_seen: cover property (stream_negative_status != 0);
endmodule
bind leadoff_gpio_config_regs leadoff_gpio_config_regs_sva #(.NCH(NCH), .NPIN(NPIN)) u_sva (
	.clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .conversion_done,
	.gpio_pin_out, .gpio_pin_oe_n, .shared_reference_switch, .single_shot_mode,
	.detect_comparator_enable, .stream_negative_status);

//--- leadoff_gpio_defines.vh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: eight channels, four general pins
// Notes: definitions only
`ifndef LEADOFF_GPIO_DEFINES_VH
`define LEADOFF_GPIO_DEFINES_VH
`define OFF_POS_DETECT_SELECT 8'h0F
`define OFF_NEG_DETECT_SELECT 8'h10
`define OFF_DIRECTION_SWAP 8'h11
`define OFF_POS_OFF_STATUS 8'h12
`define OFF_NEG_OFF_STATUS 8'h13
`define OFF_GENERAL_IO 8'h14
`define OFF_REF_SWITCH 8'h15
`define OFF_SPARE_ZERO 8'h16
`define OFF_CONV_COMP_CFG 8'h17
`define OFF_DETECT_CONTROL 8'h04
`define OFF_CH1_SETTINGS 8'h05
`define GPIO_VALUE_MSB 7
`define GPIO_VALUE_LSB 4
`define GPIO_DIR_MSB 3
`define GPIO_DIR_LSB 0
`define REF_SWITCH_BIT 5
`define SINGLE_SHOT_BIT 3
`define COMP_ENABLE_BIT 1
`define THRESH_MSB 7
`define THRESH_LSB 5
`define ILEVEL_MSB 3
`define ILEVEL_LSB 2
`define FSEL_MSB 1
`define FSEL_LSB 0
`define RST_GENERAL_IO 8'h0F
`define RST_ZERO 8'h00
`define FSEL_DC 2'h0
`define FSEL_DIV18 2'h1
`define FSEL_DIV16 2'h2
`define FSEL_RATE4 2'h3
`define MUX_BODY_DRIVE_POS 3'h6
`define MUX_BODY_DRIVE_NEG 3'h7
`define DIV18_HALF 18'h1FFFF
`define DIV16_HALF 18'h07FFF
`endif

//--- test_leadoff_gpio_config_regs.sv
// Purpose: self-checking bench for the electrode-off and pin register bank
// Assumes: host_model drives the port, bench drives the rest at falling edges
// Notes: pins resolved from drive enables; status expected only where selected
module test_leadoff_gpio_config_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, nrst = 0, conv = 0, tick = 0;
	logic [23:0] mux = 0;
	logic [7:0] praw = 0, nraw = 0, q, a, d, v;
	logic [3:0] ext = 4'h5, pins;
	wire reg_wr, ssm, sw, ce, ph;
	wire [7:0] reg_addr, reg_wdata, reg_rdata, pact, nact, pup, nup, bdp, bdn, sp, sn;
	wire [3:0] pout, poe_n;
	wire [2:0] th;
	wire [1:0] il;
	int err_total = 0, tests_run = 0;
	int n;
	always #5 clk = ~clk;
	assign pins = (~poe_n & pout) | (poe_n & ext);
	host_model h (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
	leadoff_gpio_config_regs u_dut (.clk, .nrst, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
		.channel_mux_select(mux), .conversion_done(conv), .rate_quarter_tick(tick),
		.positive_comparator_raw(praw), .negative_comparator_raw(nraw), .gpio_pin_in(pins),
		.gpio_pin_out(pout), .gpio_pin_oe_n(poe_n), .shared_reference_switch(sw),
		.single_shot_mode(ssm), .detect_comparator_enable(ce),
		.comparator_threshold_code(th), .excitation_current_level(il),
		.positive_detect_active(pact), .negative_detect_active(nact),
		.positive_pull_up(pup), .negative_pull_up(nup), .excitation_phase(ph),
		.body_drive_to_positive(bdp), .body_drive_to_negative(bdn),
		.stream_positive_status(sp), .stream_negative_status(sn));
	function automatic logic [7:0] pick(input logic [23:0] m, input logic [2:0] c);
		for (int i = 0; i < 8; i++) pick[i] = m[3*i +: 3] == c;
	endfunction
	task chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wait_toggle(output int cnt);
		logic p;
		p = ph;
		cnt = 0;
		while (ph === p && cnt < 40000) begin
			@(negedge clk);
			cnt++;
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#900us;
		err_total++;
		test_done;
	end
	initial begin
		void'($urandom(81350));
		repeat (16) @(posedge clk);
		@(negedge clk) nrst = 1;
		repeat (4) @(negedge clk);
		h.rd(8'h14, q);
		chk(q, 8'h5F);
		for (int i = 5; i < 8; i++) begin
			h.rd(8'h10 + i, q);
			chk(q, 8'h00);
			chk({5'h0, sw, ssm, ce}, 8'h00);
		end
		h.rd(8'h30, q);
		chk(q, 8'h00);
		repeat (8) begin
			d = $urandom;
			a = $urandom;
			h.wr(8'h15, d);
			h.wr(8'h16, d);
			h.wr(8'h17, ~d);
			h.wr(8'h04, {d[7:2], 2'b00});
			h.wr(8'h11, d);
			repeat (2) @(negedge clk);
			chk({sw, ssm, ce, th, il}, {d[5], ~d[3], ~d[1], d[7:5], d[3:2]});
			chk(pup, ~d);
			chk(nup, d);
			h.rd(8'h16, q);
			chk(q, 8'h00);
			ext = $urandom;
			h.wr(8'h14, {4'h0, d[3:0]});
			h.wr(8'h14, d);
			repeat (5) @(negedge clk);
			h.rd(8'h14, q);
			chk(q, {(d[3:0] & ext) | (~d[3:0] & d[7:4]), d[3:0]});
			praw = $urandom;
			nraw = $urandom;
			h.wr(8'h0F, d);
			h.wr(8'h10, ~d);
			h.wr(8'h17, a);
			@(negedge clk) conv = 1;
			@(negedge clk) conv = 0;
			repeat (2) @(negedge clk);
			chk(pact, d);
			chk(nact, ~d);
			h.wr(8'h13, 8'hFF);
			h.rd(8'h13, q);
			chk(q, nraw & ~d & {8{a[1]}});
			chk(sn, nraw & ~d & {8{a[1]}});
			h.rd(8'h12, q);
			chk(q, praw & d & {8{a[1]}});
			chk(sp, praw & d & {8{a[1]}});
			mux = {$urandom, $urandom};
			repeat (2) @(negedge clk);
			chk(bdp, pick(mux, 3'h6));
			chk(bdn, pick(mux, 3'h7));
		end
		h.wr(8'h04, 8'h03);
		repeat (3) begin
			repeat (2) @(negedge clk);
			v = {7'h0, ph};
			@(negedge clk) tick = 1;
			@(negedge clk) tick = 0;
			@(negedge clk);
			chk({7'h0, ph}, {7'h0, ~v[0]});
		end
		// divider mode: toggles 2^15 clocks apart, measured toggle to toggle
		h.wr(8'h04, 8'h02);
		wait_toggle(n);
		wait_toggle(n);
		chk(n[15:8], 8'h80);
		chk(n[7:0], 8'h00);
		// mid-run reset: defaults return, pull direction recovers after release
		@(negedge clk) nrst = 0;
		@(negedge clk);
		chk({pup[3:0], poe_n}, 8'h0F);
		@(negedge clk) nrst = 1;
		repeat (2) @(negedge clk);
		chk({sw, ssm, ce, ph, 4'h0}, 8'h00);
		chk(pup, 8'hFF);
		h.rd(8'h14, q);
		chk({4'h0, q[3:0]}, 8'h0F);
		test_done;
	end
endmodule
